/* sync_burst_sram_consts.svh */
// Widths, burst counter values, lane masks and reset values of the burst SRAM control logic.
`ifndef SYNC_BURST_SRAM_CONSTS_SVH
`define SYNC_BURST_SRAM_CONSTS_SVH

`define SRAM_ADDR_W      16
`define SRAM_DATA_W      32
`define SRAM_LANES       4
`define SRAM_LANE_W      8
`define SRAM_WORDS       65536
`define BURST_LOW_W      2
`define BURST_COUNT_INIT 2'h0
`define BURST_COUNT_STEP 2'h1
`define ALL_LANES        4'hf
`define NO_LANES         4'h0
`define DATA_RESET       32'h0000_0000

`endif

/* sync_burst_sram_pkg.sv */
// Types shared by the burst SRAM control logic.
`include "sync_burst_sram_consts.svh"

package sync_burst_sram_pkg;

    // Gray-coded cycle kinds: deselect -> read -> write.
    typedef enum logic [1:0] {
        CYC_DESELECT = 2'b00,
        CYC_READ     = 2'b01,
        CYC_WRITE    = 2'b11
    } cycle_t;

    typedef struct packed {
        cycle_t                           cycle;
        logic [`SRAM_ADDR_W-1:`BURST_LOW_W] upper_addr;
        logic [`BURST_LOW_W-1:0]          start_low;
        logic [`BURST_LOW_W-1:0]          count;
        logic [`SRAM_DATA_W-1:0]          stage_data;
        logic                             stage_drive;
        logic [`SRAM_DATA_W-1:0]          out_data;
        logic                             out_drive;
    } ctrl_state_t;

endpackage

/* sram_word_store.sv */
// Word storage array with per-lane write strobes and combinational read.
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_consts.svh"

module sram_word_store (
    input  wire logic                      clk_in,
    input  wire logic [`SRAM_ADDR_W-1:0]   addr_in,
    input  wire logic [`SRAM_LANES-1:0]    lane_write_in,
    input  wire logic [`SRAM_DATA_W-1:0]   write_data_in,
    output logic      [`SRAM_DATA_W-1:0]   read_data_out
);

    logic [`SRAM_DATA_W-1:0] words [0:`SRAM_WORDS-1];

    always_ff @(posedge clk_in) begin
        for (int i = 0; i < `SRAM_LANES; i++) begin
            if (lane_write_in[i]) begin
                words[addr_in][i*`SRAM_LANE_W +: `SRAM_LANE_W] <=
                    write_data_in[i*`SRAM_LANE_W +: `SRAM_LANE_W];
            end
        end
    end

    assign read_data_out = words[addr_in];

endmodule // sram_word_store

`default_nettype wire

/* sync_burst_sram_control.sv */
// Cycle decode, burst counter, byte-write and output gating of the burst SRAM.
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_consts.svh"

// Function
// - Linear order adds one to the low two bits per advance, wrapping after four.
// - Interleaved order gives start XOR count, wrapping after four.
// - Three select/strobe combinations make a deselect with data pins released.
// - Selected and enabled: processor strobe, or controller strobe without write, starts read.
// - Write burst starts only with controller strobe, no processor strobe, write qualifier.
// - Continue condition, advance low, no write: read next burst address.
// - Continue condition, advance low, write: write next burst address.
// - Continue condition, advance high, no write: read current address again.
// - Continue condition, advance high, write: write current address, counter held.
// - Write qualifier: global write low, or byte gate low with some lane low.
// - Byte writes store exactly the lanes whose enables are low.
// - Reads drive all four lanes regardless of lane enables.
// - With bypass low, data pins stay released during every write; with bypass high, a preceding read still drives them.
// - Output enable high turns drivers off at once, at any time.
// - Output enable low only lets pins drive in decoded read cycles.
// - Burst order pin low selects linear, high selects interleaved.
// - Deselect is pipelined exactly like a read before drivers turn off.
// - Reads with output enable high still advance the counter normally.
module sync_burst_sram_control (
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    input  wire logic [`SRAM_ADDR_W-1:0]   address_in,
    input  wire logic [`SRAM_DATA_W-1:0]   data_in,
    input  wire logic                      chip_select_low_first_n_in,
    input  wire logic                      chip_select_high_in,
    input  wire logic                      chip_select_low_second_n_in,
    input  wire logic                      processor_address_strobe_n_in,
    input  wire logic                      controller_address_strobe_n_in,
    input  wire logic                      burst_step_request_n_in,
    input  wire logic                      global_write_all_n_in,
    input  wire logic                      byte_write_gate_n_in,
    input  wire logic                      byte_lane_enable_a_n_in,
    input  wire logic                      byte_lane_enable_b_n_in,
    input  wire logic                      byte_lane_enable_c_n_in,
    input  wire logic                      byte_lane_enable_d_n_in,
    input  wire logic                      output_enable_n_in,
    input  wire logic                      burst_order_select_in,
    input  wire logic                      output_register_bypass_in,
    output logic      [`SRAM_DATA_W-1:0]   data_out,
    output logic      [`SRAM_LANES-1:0]    data_oe_out
);

    sync_burst_sram_pkg::ctrl_state_t state_reg;
    sync_burst_sram_pkg::ctrl_state_t state_next;

    logic [`SRAM_LANES-1:0]  lane_n;
    logic                    enable_true;
    logic                    write_qual;
    logic                    deselect;
    logic                    begin_read;
    logic                    begin_write;
    logic                    continue_ok;
    logic                    access;
    logic                    is_write;
    logic [`BURST_LOW_W-1:0] use_count;
    logic [`SRAM_ADDR_W-1:0] access_addr;
    logic [`SRAM_LANES-1:0]  lane_write;
    logic [`SRAM_DATA_W-1:0] read_word;

    // Low address bits of the burst for a given start and count.
    function automatic logic [`BURST_LOW_W-1:0] burst_low(
        input logic [`BURST_LOW_W-1:0] start,
        input logic [`BURST_LOW_W-1:0] count,
        input logic                    interleave
    );
        if (interleave) begin
            burst_low = start ^ count;
        end else begin
            burst_low = start + count;
        end
    endfunction

    assign lane_n = {byte_lane_enable_d_n_in, byte_lane_enable_c_n_in,
                     byte_lane_enable_b_n_in, byte_lane_enable_a_n_in};

    always_comb begin
        enable_true = chip_select_high_in & ~chip_select_low_second_n_in;
        write_qual  = ~global_write_all_n_in
                    | (~byte_write_gate_n_in & ~(&lane_n));
        deselect    = (chip_select_low_first_n_in & ~controller_address_strobe_n_in)
                    | (~chip_select_low_first_n_in & ~enable_true
                       & ~processor_address_strobe_n_in)
                    | (~chip_select_low_first_n_in & ~enable_true
                       & processor_address_strobe_n_in
                       & ~controller_address_strobe_n_in);
        begin_read  = ~chip_select_low_first_n_in & enable_true
                    & (~processor_address_strobe_n_in
                       | (~controller_address_strobe_n_in & ~write_qual));
        begin_write = ~chip_select_low_first_n_in & enable_true
                    & processor_address_strobe_n_in
                    & ~controller_address_strobe_n_in & write_qual;
        continue_ok = controller_address_strobe_n_in
                    & (processor_address_strobe_n_in | chip_select_low_first_n_in);
        access      = begin_read | begin_write | continue_ok;
        is_write    = begin_write | (continue_ok & write_qual);

        state_next = state_reg;
        use_count  = state_reg.count;
        access_addr = address_in;

        if (begin_read | begin_write) begin
            // A new burst latches the whole external address.
            state_next.upper_addr = address_in[`SRAM_ADDR_W-1:`BURST_LOW_W];
            state_next.start_low  = address_in[`BURST_LOW_W-1:0];
            state_next.count      = `BURST_COUNT_INIT;
        end else if (continue_ok) begin
            if (!burst_step_request_n_in) begin
                use_count        = state_reg.count + `BURST_COUNT_STEP;
                state_next.count = use_count;
            end
            // Advance high reuses the current count.
            access_addr = {state_reg.upper_addr,
                           burst_low(state_reg.start_low, use_count,
                                     burst_order_select_in)};
        end

        if (deselect) begin
            state_next.cycle = sync_burst_sram_pkg::CYC_DESELECT;
        end else if (access & is_write) begin
            state_next.cycle = sync_burst_sram_pkg::CYC_WRITE;
        end else if (access) begin
            state_next.cycle = sync_burst_sram_pkg::CYC_READ;
        end

        if (deselect | ~access) begin
            lane_write = `NO_LANES;
        end else if (is_write & ~global_write_all_n_in) begin
            lane_write = `ALL_LANES;
        end else if (is_write) begin
            lane_write = ~lane_n;
        end else begin
            lane_write = `NO_LANES;
        end

        // Reads drive every lane; writes and deselects release the pins.
        state_next.stage_drive = access & ~deselect & ~is_write;
        state_next.stage_data  = read_word;

        // Bypass high takes data from the extra stage, so deselects lag like reads.
        if (output_register_bypass_in) begin
            state_next.out_drive = state_reg.stage_drive;
            state_next.out_data  = state_reg.stage_data;
        end else begin
            state_next.out_drive = state_next.stage_drive;
            state_next.out_data  = read_word;
        end

        if (srst_in) begin
            state_next.cycle       = sync_burst_sram_pkg::CYC_DESELECT;
            state_next.upper_addr  = '0;
            state_next.start_low   = `BURST_COUNT_INIT;
            state_next.count       = `BURST_COUNT_INIT;
            state_next.stage_data  = `DATA_RESET;
            state_next.stage_drive = 1'b0;
            state_next.out_data    = `DATA_RESET;
            state_next.out_drive   = 1'b0;
            lane_write             = `NO_LANES;
        end
    end

    sram_word_store store (
        .clk_in        (clk_in),
        .addr_in       (access_addr),
        .lane_write_in (lane_write),
        .write_data_in (data_in),
        .read_data_out (read_word)
    );

    always_ff @(posedge clk_in) begin
        state_reg <= state_next;
    end

    assign data_out = state_reg.out_data;

    // The output enable acts without the clock, so it gates the registered drive.
    assign data_oe_out = {`SRAM_LANES{state_reg.out_drive & ~output_enable_n_in}};

endmodule // sync_burst_sram_control

`default_nettype wire

/* sync_burst_sram_control_checker.sv */
// Port-level assertions for the burst SRAM control block.
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_consts.svh"
module sync_burst_sram_control_checker (
    input wire logic                    clk_in,
    input wire logic                    srst_in,
    input wire logic                    chip_select_low_first_n_in,
    input wire logic                    chip_select_high_in,
    input wire logic                    chip_select_low_second_n_in,
    input wire logic                    processor_address_strobe_n_in,
    input wire logic                    controller_address_strobe_n_in,
    input wire logic                    global_write_all_n_in,
    input wire logic                    byte_write_gate_n_in,
    input wire logic                    byte_lane_enable_a_n_in,
    input wire logic                    byte_lane_enable_b_n_in,
    input wire logic                    byte_lane_enable_c_n_in,
    input wire logic                    byte_lane_enable_d_n_in,
    input wire logic                    output_enable_n_in,
    input wire logic                    output_register_bypass_in,
    input wire logic [`SRAM_LANES-1:0]  data_oe_out
);
    logic s1, p, c, en, wq, rd_go, wr_go, dsel, cont, pipe;
    assign s1 = chip_select_low_first_n_in;
    assign p = processor_address_strobe_n_in;
    assign c = controller_address_strobe_n_in;
    assign pipe = output_register_bypass_in;
    assign en = chip_select_high_in && !chip_select_low_second_n_in;
    assign wq = !global_write_all_n_in || (!byte_write_gate_n_in && !(byte_lane_enable_a_n_in
        && byte_lane_enable_b_n_in && byte_lane_enable_c_n_in && byte_lane_enable_d_n_in));
    assign dsel = (s1 && !c) || (!s1 && !en && (!p || !c));
    assign rd_go = !s1 && en && (!p || (!c && !wq));
    assign wr_go = !s1 && en && p && !c && wq;
    assign cont = c && (p || s1);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence flow_read; !pipe && (rd_go || (cont && !wq)); endsequence
    sequence oe_on; !output_enable_n_in; endsequence
    oe_off_a: assert property (output_enable_n_in |-> data_oe_out == 4'h0)
        else $error("lanes driven with output enable high");
    lanes_all_a: assert property (data_oe_out == 4'h0 || data_oe_out == 4'hf)
        else $error("partial lane drive");
    flow_rd_a: assert property (flow_read ##1 oe_on |-> data_oe_out == 4'hf)
        else $error("read not driven");
    flow_wr_a: assert property (!pipe && (wr_go || (cont && wq)) |=> data_oe_out == 4'h0)
        else $error("write drove pins");
    flow_dsel_a: assert property (!pipe && dsel |=> data_oe_out == 4'h0)
        else $error("deselect drove pins");
    pipe_rd_a: assert property (pipe && rd_go ##1 pipe ##1 oe_on |-> data_oe_out == 4'hf)
        else $error("pipelined read not driven");
    pipe_dsel_a: assert property (pipe && dsel |=> ##1 data_oe_out == 4'h0)
        else $error("pipelined deselect drove pins");
    cont_rd_a: assert property (!pipe && cont && !wq ##1 oe_on |-> data_oe_out == 4'hf)
        else $error("continued read not driven");
endmodule // sync_burst_sram_control_checker
bind sync_burst_sram_control sync_burst_sram_control_checker chk (.clk_in, .srst_in,
    .chip_select_low_first_n_in, .chip_select_high_in, .chip_select_low_second_n_in,
    .processor_address_strobe_n_in, .controller_address_strobe_n_in, .global_write_all_n_in,
    .byte_write_gate_n_in, .byte_lane_enable_a_n_in, .byte_lane_enable_b_n_in,
    .byte_lane_enable_c_n_in, .byte_lane_enable_d_n_in, .output_enable_n_in,
    .output_register_bypass_in, .data_oe_out);
`default_nettype wire

/* sram_bus_master.sv */
// Controller model holding the synchronous SRAM bus pins between clock edges.
`timescale 1ns/10ps
`default_nettype none
module sram_bus_master (
    output var logic [2:0]  sel_out,
    output var logic [1:0]  strobe_n_out,
    output var logic        step_n_out,
    output var logic [5:0]  write_n_out,
    output var logic [15:0] addr_out,
    output var logic [31:0] data_out
);
    initial begin
        // Idle as a deselect, so nothing is read before the first command.
        sel_out = 3'h7;
        strobe_n_out = 2'h2;
        step_n_out = 1'b1;
        write_n_out = 6'h3f;
        addr_out = 16'h0000;
        data_out = 32'h0000_0000;
    end
    task automatic put(input logic [2:0] s, input logic [1:0] t, input logic v,
                       input logic [5:0] w, input logic [15:0] a, input logic [31:0] d);
        sel_out = s;
        strobe_n_out = t;
        step_n_out = v;
        write_n_out = w;
        addr_out = a;
        // Outside writes the data lines toggle so a stale word is never mistaken for data.
        data_out = (w[5] && (w[4] || &w[3:0])) ? ~data_out : d;
    endtask
endmodule // sram_bus_master
`default_nettype wire

/* sync_burst_sram_control_tb.sv */
// Self-checking testbench of the burst SRAM control block.
`timescale 1ns/10ps
`default_nettype none
module sync_burst_sram_control_tb;
    logic        clk_in = 1'b0, srst_in = 1'b1, oe_n = 1'b0, order = 1'b0, bypass = 1'b0;
    logic [2:0]  sel;
    logic [1:0]  st;
    logic        step_n;
    logic [5:0]  w;
    logic [15:0] a;
    logic [31:0] d, dq, mem [0:65535];
    logic [3:0]  dqe;
    logic [33:0] hist [1:2] = '{34'h0, 34'h0};
    int          errors = 0, checks = 0;
    logic [3:0]  lane_sets [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h5};
    localparam logic [33:0] OFF = 34'h1_0000_0000;
    always #5 clk_in = ~clk_in;
    sram_bus_master m (.sel_out(sel), .strobe_n_out(st), .step_n_out(step_n),
        .write_n_out(w), .addr_out(a), .data_out(d));
    sync_burst_sram_control uut (.clk_in(clk_in), .srst_in(srst_in), .address_in(a),
        .data_in(d), .chip_select_low_first_n_in(sel[2]), .chip_select_high_in(sel[1]),
        .chip_select_low_second_n_in(sel[0]), .processor_address_strobe_n_in(st[1]),
        .controller_address_strobe_n_in(st[0]), .burst_step_request_n_in(step_n),
        .global_write_all_n_in(w[5]), .byte_write_gate_n_in(w[4]),
        .byte_lane_enable_a_n_in(w[0]), .byte_lane_enable_b_n_in(w[1]),
        .byte_lane_enable_c_n_in(w[2]), .byte_lane_enable_d_n_in(w[3]),
        .output_enable_n_in(oe_n), .burst_order_select_in(order),
        .output_register_bypass_in(bypass), .data_out(dq), .data_oe_out(dqe));
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One bus cycle: judge the result now due, then present the next command.
    task automatic cyc(input logic [2:0] s, input logic [1:0] t, input logic v,
        input logic [5:0] wn, input logic [15:0] ap, input logic [31:0] dt, input logic [33:0] e);
        logic [33:0] h;
        @(posedge clk_in);
        #1;
        h = hist[bypass ? 2 : 1];
        if (h[33] && !oe_n) chk({dqe, dq}, {4'hf, h[31:0]});
        else if (h[33] || h[32]) chk({dqe, 32'h0}, 36'h0);
        hist[2] = hist[1];
        hist[1] = e;
        m.put(s, t, v, wn, ap, dt);
    endtask
    task automatic wr(input logic [2:0] s, input logic [1:0] t, input logic v,
        input logic [5:0] wn, input logic [15:0] ap, ae, input logic [31:0] dt);
        cyc(s, t, v, wn, ap, dt, OFF);
        for (int i = 0; i < 4; i++)
            if (!wn[5] || !wn[i]) mem[ae][8*i+:8] = dt[8*i+:8];
    endtask
    task automatic rd(input logic [2:0] s, input logic [1:0] t, input logic v,
        input logic [5:0] wn, input logic [15:0] ap, ae);
        cyc(s, t, v, wn, ap, 32'h0, {2'b10, mem[ae]});
    endtask
    task automatic summarize;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        #1 srst_in = 1'b0;
        wr(3'h2, 2'h2, 1'b1, 6'h1f, 16'h1232, 16'h1232, 32'ha5a5_0000);
        for (int n = 1; n < 4; n++)
            wr(3'h4, 2'h3, 1'b0, 6'h1f, 16'hffff, {14'h48c, 2'(2 + n)}, 32'ha5a5_0000 + n);
        foreach (lane_sets[k])
            wr(3'h2, 2'h3, 1'b1, {2'b10, lane_sets[k]}, 16'hffff, 16'h1231,
               32'h1111_1111 * (k + 2));
        rd(3'h2, 2'h3, 1'b1, 6'h2f, 16'hffff, 16'h1231);
        rd(3'h2, 2'h1, 1'b1, 6'h00, 16'h1232, 16'h1232);
        for (int n = 1; n < 5; n++)
            rd(3'h4, 2'h3, 1'b0, 6'h3f, 16'hffff, {14'h48c, 2'(2 + n)});
        rd(3'h4, 2'h3, 1'b1, 6'h3f, 16'hffff, 16'h1232);
        rd(3'h4, 2'h3, 1'b0, 6'h3f, 16'hffff, 16'h1233);
        oe_n = 1'b1;
        rd(3'h4, 2'h3, 1'b0, 6'h3f, 16'hffff, 16'h1230);
        // The dummy read above is judged released; this one shows that it still advanced.
        rd(3'h4, 2'h3, 1'b0, 6'h3f, 16'hffff, 16'h1231);
        oe_n = 1'b0;
        order = 1'b1;
        rd(3'h2, 2'h2, 1'b0, 6'h3f, 16'h1231, 16'h1231);
        for (int n = 1; n < 5; n++)
            rd(3'h2, 2'h3, 1'b0, 6'h3f, 16'h0000, {14'h48c, 2'(1 ^ n)});
        wr(3'h2, 2'h2, 1'b1, 6'h1f, 16'h2234, 16'h2234, 32'h0f1e_2d3c);
        rd(3'h2, 2'h2, 1'b1, 6'h3f, 16'h2234, 16'h2234);
        rd(3'h2, 2'h2, 1'b1, 6'h3f, 16'h1233, 16'h1233);
        cyc(3'h6, 2'h2, 1'b0, 6'h3f, 16'h0, 32'h0, OFF);
        cyc(3'h0, 2'h1, 1'b0, 6'h3f, 16'h0, 32'h0, OFF);
        cyc(3'h3, 2'h2, 1'b0, 6'h3f, 16'h0, 32'h0, OFF);
        cyc(3'h6, 2'h2, 1'b0, 6'h3f, 16'h0, 32'h0, OFF);
        srst_in = 1'b1;
        bypass = 1'b1;
        hist = '{34'h0, 34'h0};
        @(posedge clk_in);
        #1 srst_in = 1'b0;
        rd(3'h2, 2'h1, 1'b1, 6'h3f, 16'h1232, 16'h1232);
        for (int n = 1; n < 4; n++)
            rd(3'h2, 2'h3, 1'b0, 6'h3f, 16'hffff, {14'h48c, 2'(2 ^ n)});
        repeat (3) cyc(3'h6, 2'h2, 1'b0, 6'h3f, 16'h0, 32'h0, OFF);
        summarize();
    end
endmodule // sync_burst_sram_control_tb
`default_nettype wire
